// ===== rtl/gpio_pkg.sv
// Package with register map, reset values and field positions of the I/O port
package gpio_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFS_DIRECTION = 12'h000;
	localparam logic [11:0] OFS_PIN_LEVEL = 12'h004;
	localparam logic [11:0] OFS_OUTPUT_LATCH = 12'h008;
	localparam logic [11:0] OFS_ANALOG_SELECT = 12'h00C;
	localparam logic [11:0] OFS_ALT_PIN_SELECT = 12'h010;
	// ----------------------------------------
	// Reset values and masks
	// ----------------------------------------
	localparam logic [7:0] DIRECTION_RESET = 8'hFF;
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] ANALOG_RESET = 8'h2F;
	localparam logic [7:0] ANALOG_MASK = 8'h2F;
	localparam logic [7:0] ALT_SELECT_RESET = 8'h00;
	localparam logic [7:0] ALT_SELECT_MASK = 8'h03;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int COMPARE_UNIT2_SEL_BIT = 0;
	localparam int SLAVE_SELECT_SEL_BIT = 1;
	localparam int PIN_CORE_CAP = 5;
	localparam int PIN_CLOCK_OUT = 6;
	localparam int PIN_SLAVE_SELECT_DEFAULT = 5;
	localparam int PIN_SLAVE_SELECT_ALT = 0;
endpackage : gpio_pkg

// ===== rtl/pin_sync.sv
// Two-flop synchroniser for the pin input levels
module pin_sync
	import gpio_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	// First stage feeds only the second
	always_comb begin
		state_next.stage1 = async_in;
		state_next.stage2 = state_reg.stage1;
	end

	// Register both stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sync_out = state_reg.stage2;
endmodule : pin_sync

// ===== rtl/pin_output_mux.sv
// Per-pin output ownership by fixed priority
module pin_output_mux
	import gpio_pkg::*;
(
	// Port data
	input wire logic [7:0] direction,
	input wire logic [7:0] latch,
	// Peripheral functions
	input wire logic core_cap_en,
	input wire logic clock_out_en,
	input wire logic clock_out_val,
	input wire logic osc_out_en,
	input wire logic osc_out_val,
	// Pin drive
	output logic [7:0] pad_out,
	output logic [7:0] pad_oe
);
	// Highest enabled function wins; analog select plays no part
	always_comb begin
		pad_out = latch;
		pad_oe = ~direction;
		if (core_cap_en) begin
			pad_out[PIN_CORE_CAP] = 1'b0;
			pad_oe[PIN_CORE_CAP] = 1'b0;
		end
		if (clock_out_en) begin
			pad_out[PIN_CLOCK_OUT] = clock_out_val;
			pad_oe[PIN_CLOCK_OUT] = 1'b1;
		end else if (osc_out_en) begin
			pad_out[PIN_CLOCK_OUT] = osc_out_val;
			pad_oe[PIN_CLOCK_OUT] = 1'b1;
		end
	end
endmodule : pin_output_mux

// ===== rtl/gpio_port.sv
// Top of the 8-bit general purpose port with APB register access
//
// The register offsets and the APB interface to the registers were left to the implementer.
module gpio_port
	import gpio_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Port A pins
	input wire logic [7:0] pin_a_in,
	output logic [7:0] pin_a_out,
	output logic [7:0] pin_a_oe,
	// Analog enable per pin
	output logic [7:0] analog_en,
	// Special pin functions
	input wire logic core_cap_en,
	input wire logic clock_out_en,
	input wire logic clock_out_val,
	input wire logic osc_out_en,
	input wire logic osc_out_val,
	// Slave-select routing
	output logic [7:0] slave_select_in,
	// Compare unit 2 routing
	input wire logic compare_unit2_en,
	input wire logic compare_unit2_out,
	output logic compare_unit2_in,
	output logic compare_unit2_on_c1,
	output logic compare_unit2_on_b3,
	// Pin levels of the remote pins
	input wire logic pin_c1_in,
	input wire logic pin_b3_in
);
	typedef struct packed {
		logic [7:0] direction;
		logic [7:0] latch;
		logic [7:0] analog;
		logic [7:0] alt_sel;
		logic [31:0] rdata;
	} port_state_t;

	port_state_t state_reg;
	port_state_t state_next;
	logic [7:0] pins_sync;
	logic [7:0] pin_read;
	logic [1:0] remote_sync;
	logic access;
	logic mapped;
	logic ss_level;

	// ----------------------------------------
	// Pin sampling
	// ----------------------------------------
	pin_sync #(.WIDTH(10)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({pin_b3_in, pin_c1_in, pin_a_in}),
		.sync_out({remote_sync, pins_sync})
	);

	// Analog pins read as zero
	assign pin_read = pins_sync & ~state_reg.analog;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	function automatic logic is_mapped(input logic [11:0] addr);
		is_mapped = (addr == OFS_DIRECTION) || (addr == OFS_PIN_LEVEL) ||
			(addr == OFS_OUTPUT_LATCH) || (addr == OFS_ANALOG_SELECT) ||
			(addr == OFS_ALT_PIN_SELECT);
	endfunction : is_mapped

	assign access = psel && penable;
	assign mapped = is_mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata = state_reg.rdata;

	// Next state of registers and read data
	always_comb begin
		state_next = state_reg;
		state_next.rdata = '0;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFS_DIRECTION: state_next.rdata = {24'h000000, state_reg.direction};
				OFS_PIN_LEVEL: state_next.rdata = {24'h000000, pin_read};
				OFS_OUTPUT_LATCH: state_next.rdata = {24'h000000, state_reg.latch};
				OFS_ANALOG_SELECT: state_next.rdata = {24'h000000, state_reg.analog};
				OFS_ALT_PIN_SELECT: state_next.rdata = {24'h000000, state_reg.alt_sel};
				default: state_next.rdata = '0;
			endcase
		end else if (psel && penable && !pwrite) begin
			state_next.rdata = state_reg.rdata;
		end
		if (access && pwrite && pstrb[0]) begin
			unique case (paddr)
				OFS_DIRECTION: state_next.direction = pwdata[7:0];
				OFS_PIN_LEVEL, OFS_OUTPUT_LATCH: begin
					// Whole-byte write over the pin image; latch takes it now
					state_next.latch = pwdata[7:0];
				end
				OFS_ANALOG_SELECT: state_next.analog = pwdata[7:0] & ANALOG_MASK;
				OFS_ALT_PIN_SELECT: begin
					state_next.alt_sel = pwdata[7:0] & ALT_SELECT_MASK;
				end
				default: state_next.analog = state_reg.analog;
			endcase
		end
	end

	// Register the whole state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.direction <= DIRECTION_RESET;
			state_reg.latch <= LATCH_RESET;
			state_reg.analog <= ANALOG_RESET;
			state_reg.alt_sel <= ALT_SELECT_RESET;
			state_reg.rdata <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Pin drive
	// ----------------------------------------
	pin_output_mux u_mux (
		.direction(state_reg.direction),
		.latch(state_reg.latch),
		.core_cap_en(core_cap_en),
		.clock_out_en(clock_out_en),
		.clock_out_val(clock_out_val),
		.osc_out_en(osc_out_en),
		.osc_out_val(osc_out_val),
		.pad_out(pin_a_out),
		.pad_oe(pin_a_oe)
	);

	assign analog_en = state_reg.analog;

	// ----------------------------------------
	// Alternate pin routing
	// ----------------------------------------
	// Slave select follows the chosen pin; direction untouched
	assign ss_level = state_reg.alt_sel[SLAVE_SELECT_SEL_BIT] ?
		pin_read[PIN_SLAVE_SELECT_ALT] : pin_read[PIN_SLAVE_SELECT_DEFAULT];
	assign slave_select_in = {7'h00, ss_level};

	// Compare unit 2 owns only the selected remote pin
	assign compare_unit2_on_c1 = compare_unit2_en &&
		!state_reg.alt_sel[COMPARE_UNIT2_SEL_BIT];
	assign compare_unit2_on_b3 = compare_unit2_en &&
		state_reg.alt_sel[COMPARE_UNIT2_SEL_BIT];
	assign compare_unit2_in = state_reg.alt_sel[COMPARE_UNIT2_SEL_BIT] ?
		remote_sync[1] : remote_sync[0];
endmodule : gpio_port

// ===== tb/gpio_port_checker.sv
// Checker of pin and bus timing at the port top
module gpio_port_checker
	import gpio_pkg::*;
(
	// Clock, reset and bus
	input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
	input wire logic [11:0] paddr,
	// Pins and functions
	input wire logic [7:0] pin_a_out, pin_a_oe, analog_en, slave_select_in,
	input wire logic core_cap_en, clock_out_en, clock_out_val, osc_out_en, osc_out_val
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase and a write to the pin select
	sequence acc_s; psel && penable; endsequence
	sequence alt_wr_s; acc_s ##0 (pwrite && paddr == OFS_ALT_PIN_SELECT); endsequence
	bus_ready_a: assert property (acc_s |-> pready)
		else $error("access not answered");
	unmapped_err_a: assert property (acc_s ##0 (paddr > 12'h010) |-> pslverr)
		else $error("unmapped access not refused");
	core_cap_a: assert property (core_cap_en |-> !pin_a_oe[5])
		else $error("pin 5 still driven");
	clock_out_a: assert property (clock_out_en |-> pin_a_oe[6] && pin_a_out[6] == clock_out_val)
		else $error("clock out lost pin 6");
	osc_out_a: assert property (!clock_out_en && osc_out_en |-> pin_a_oe[6] && pin_a_out[6] == osc_out_val)
		else $error("osc out lost pin 6");
	analog_bits_a: assert property ((analog_en & 8'hD0) == 8'h00)
		else $error("unimplemented analog bit set");
	ss_spare_a: assert property (slave_select_in[7:1] == 7'h00)
		else $error("spare select bits set");
	alt_oe_a: assert property (alt_wr_s ##1 $stable({core_cap_en, clock_out_en, osc_out_en}) |-> $stable(pin_a_oe))
		else $error("pin select moved a driver");
endmodule : gpio_port_checker

// ===== tb/pin_partner.sv
// Far-side pin model resolving drivers onto the pads
module pin_partner (
	// Device drive and external sources
	input wire logic [7:0] pad_out, pad_oe, ext_drive,
	// Levels seen at the pads
	output logic [7:0] pad_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// A driving device wins, else the outside source sets the level
	assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_drive);
endmodule : pin_partner

// ===== tb/testbench.sv
// Self-checking bench for the port
module testbench
	import gpio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [7:0] pin_a_in, pin_a_out, pin_a_oe, analog_en, ss_in, ext = '0, d, l, a;
	logic cc = 0, co = 0, cv = 0, oe6 = 0, ov = 0, ce = 0, cout = 0, c1 = 0, b3 = 0;
	logic cu_in, on_c1, on_b3;
	logic [3:0] strb = 4'hF;
	int errors = 0, checks_done = 0;
	// Clock and partner
	initial forever #50 pclk = ~pclk;
	pin_partner far (.pad_out(pin_a_out), .pad_oe(pin_a_oe), .ext_drive(ext), .pad_level(pin_a_in));
	gpio_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_a_in(pin_a_in), .pin_a_out(pin_a_out),
		.pin_a_oe(pin_a_oe), .analog_en(analog_en), .core_cap_en(cc), .clock_out_en(co),
		.clock_out_val(cv), .osc_out_en(oe6), .osc_out_val(ov), .slave_select_in(ss_in),
		.compare_unit2_en(ce), .compare_unit2_out(cout), .compare_unit2_in(cu_in),
		.compare_unit2_on_c1(on_c1), .compare_unit2_on_b3(on_b3), .pin_c1_in(c1),
		.pin_b3_in(b3));
	// Expected digital pin read
	function automatic logic [7:0] lvl(input logic [7:0] dr, la, ex, an);
		return ((~dr & la) | (dr & ex)) & ~(an & ANALOG_MASK);
	endfunction : lvl
	task automatic check(input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// One bus transfer, held until ready is seen at a rising edge, then an idle cycle
	task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		// Answer taken at the edge that completes the access
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	initial begin
		#1000000;
		errors++;
		conclude();
	end
	initial begin
		void'($urandom(32'hBEA3));
		repeat (4) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		xfer(0, OFS_DIRECTION, 0);
		check(rd[7:0], 8'hFF);
		xfer(0, OFS_ANALOG_SELECT, 0);
		check(rd[7:0], 8'h2F);
		check(pin_a_oe, 8'h00);
		$display("test reset done");
		repeat (24) begin
			d = 8'($urandom);
			l = 8'($urandom);
			a = 8'($urandom);
			ext <= 8'($urandom);
			xfer(1, OFS_DIRECTION, d);
			xfer(1, OFS_ANALOG_SELECT, a);
			xfer(1, $urandom_range(1) ? OFS_PIN_LEVEL : OFS_OUTPUT_LATCH, l);
			repeat (3) @(posedge pclk);
			check(pin_a_oe, ~d);
			check(pin_a_out & ~d, l & ~d);
			xfer(0, OFS_PIN_LEVEL, 0);
			check(rd[7:0], lvl(d, l, ext, a));
			xfer(0, OFS_OUTPUT_LATCH, 0);
			check(rd[7:0], l);
			xfer(0, OFS_ANALOG_SELECT, 0);
			check(rd[7:0], a & ANALOG_MASK);
			check(analog_en, a & ANALOG_MASK);
		end
		$display("test port data done");
		xfer(1, OFS_DIRECTION, 0);
		repeat (8) begin
			{cc, co, cv, oe6, ov} <= 5'($urandom);
			@(posedge pclk);
			@(posedge pclk);
			check({pin_a_oe[5], pin_a_out[6]}, {!cc, co ? cv : (oe6 ? ov : l[6])});
		end
		{cc, co, oe6} <= 3'h0;
		@(posedge pclk);
		$display("test functions done");
		presetn <= 0;
		@(posedge pclk) presetn <= 1;
		@(posedge pclk);
		check(pin_a_oe, 8'h00);
		xfer(1, OFS_ANALOG_SELECT, 0);
		ce <= 1;
		for (int s = 0; s < 4; s++) begin
			xfer(1, OFS_ALT_PIN_SELECT, 32'hFC + s);
			xfer(0, OFS_ALT_PIN_SELECT, 0);
			check(rd[7:0], 8'(s));
			ext <= 8'($urandom);
			c1 <= 1'($urandom);
			b3 <= 1'($urandom);
			cout <= 1'($urandom);
			repeat (3) @(posedge pclk);
			check(ss_in[0], s[1] ? ext[0] : ext[5]);
			check({on_b3, on_c1, cu_in}, {s[0], !s[0], s[0] ? b3 : c1});
			check(pin_a_oe, 8'h00);
		end
		$display("test pin select done");
		xfer(1, 12'h020, 32'hFF);
		check(err, 1);
		xfer(0, 12'h020, 0);
		check(err, 1);
		check(rd[7:0], 8'h00);
		strb <= 4'h0;
		xfer(1, OFS_DIRECTION, 0);
		strb <= 4'hF;
		xfer(0, OFS_DIRECTION, 0);
		check(rd[7:0], DIRECTION_RESET);
		$display("test unmapped done");
		conclude();
	end
endmodule : testbench
bind gpio_port gpio_port_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr),
	.pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe), .analog_en(analog_en),
	.slave_select_in(slave_select_in), .core_cap_en(core_cap_en), .clock_out_en(clock_out_en),
	.clock_out_val(clock_out_val), .osc_out_en(osc_out_en), .osc_out_val(osc_out_val));
